// ### crc_engine_cfg.svh
// Constants of the programmable CRC engine: register indices, control
// field positions, reset values and bus encodings.
// Assumes nothing; included by the package and the engine.
`ifndef CRC_ENGINE_CFG_SVH
`define CRC_ENGINE_CFG_SVH

// Register indices; the byte address is four times the index
`define CRC_IDX_CHECKSUM_BYTE_3 4'h0
`define CRC_IDX_CHECKSUM_BYTE_2 4'h1
`define CRC_IDX_CHECKSUM_BYTE_1 4'h2
`define CRC_IDX_CHECKSUM_BYTE_0 4'h3
`define CRC_IDX_POLY_BYTE_3 4'h4
`define CRC_IDX_POLY_BYTE_2 4'h5
`define CRC_IDX_POLY_BYTE_1 4'h6
`define CRC_IDX_POLY_BYTE_0 4'h7
`define CRC_IDX_CONTROL 4'h8

// Field positions in control_settings
`define CRC_CTRL_IN_REV_LSB 6
`define CRC_CTRL_OUT_REV_LSB 4
`define CRC_CTRL_RSV_BIT 3
`define CRC_CTRL_INVERT_BIT 2
`define CRC_CTRL_SEED_SEL_BIT 1
`define CRC_CTRL_WIDTH_BIT 0

// Reset values
`define CRC_CHECKSUM_RST 32'hffffffff
`define CRC_POLY_RST 32'h00001021
`define CRC_CTRL_RST 8'h00

// AHB-Lite encodings
`define CRC_HSIZE_WORD 3'h2

`endif

// ### crc_engine_pkg.sv
// Types and small helpers shared by the CRC engine files.
// Assumes the constants header is on the include path.
`include "crc_engine_cfg.svh"

package crc_engine_pkg;

  typedef logic [3:0] reg_idx_t;

  typedef enum logic [1:0] {
    REV_NONE = 2'h0,
    REV_BITS = 2'h1,
    REV_RSV2 = 2'h2,
    REV_RSV3 = 2'h3
  } rev_sel_e;

  typedef struct packed {
    rev_sel_e input_reverse_sel;
    rev_sel_e output_reverse_sel;
    logic result_invert;
    logic seed_write_select;
    logic width_select;
  } ctrl_s;

  function automatic logic [7:0] rev8(logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  function automatic ctrl_s unpack_ctrl(logic [7:0] b);
    ctrl_s c;
    c.input_reverse_sel = rev_sel_e'(b[`CRC_CTRL_IN_REV_LSB +: 2]);
    c.output_reverse_sel = rev_sel_e'(b[`CRC_CTRL_OUT_REV_LSB +: 2]);
    c.result_invert = b[`CRC_CTRL_INVERT_BIT];
    c.seed_write_select = b[`CRC_CTRL_SEED_SEL_BIT];
    c.width_select = b[`CRC_CTRL_WIDTH_BIT];
    return c;
  endfunction

  function automatic logic [7:0] pack_ctrl(ctrl_s c);
    logic [7:0] b;
    b = 8'h00;
    b[`CRC_CTRL_IN_REV_LSB +: 2] = c.input_reverse_sel;
    b[`CRC_CTRL_OUT_REV_LSB +: 2] = c.output_reverse_sel;
    b[`CRC_CTRL_INVERT_BIT] = c.result_invert;
    b[`CRC_CTRL_SEED_SEL_BIT] = c.seed_write_select;
    b[`CRC_CTRL_WIDTH_BIT] = c.width_select;
    return b;
  endfunction

endpackage

// ### crc_step_if.sv
// Interface between the engine and its byte update unit.
// Assumes the unit is purely combinational.
`timescale 1ns/1ps

interface crc_step_if;
  logic [31:0] crc_in;
  logic [31:0] poly;
  logic [7:0] data;
  logic wide;
  logic [31:0] crc_out;

  modport unit (input crc_in, input poly, input data, input wide,
    output crc_out);
  modport user (output crc_in, output poly, output data, output wide,
    input crc_out);
endinterface

// ### crc_byte_step.sv
// Combinational update of a running CRC by one message byte.
// Assumes the caller has already applied any input bit reversal.
`timescale 1ns/1ps

module crc_byte_step (
  // Step operands and result
  crc_step_if.unit p
);

  logic [31:0] st [0:8];

  assign st[0] = p.crc_in;

  // Most significant message bit enters first
  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic fb;
    logic [31:0] sh16;
    assign fb = (p.wide ? st[i][31] : st[i][15]) ^ p.data[7-i];
    // Narrow mode shifts only the low half; the high half is frozen
    assign sh16 = {st[i][31:16], st[i][14:0], 1'b0};
    assign st[i+1] = p.wide ?
      ({st[i][30:0], 1'b0} ^ (fb ? p.poly : 32'h00000000)) :
      (sh16 ^ (fb ? {16'h0000, p.poly[15:0]} : 32'h00000000));
  end

  assign p.crc_out = st[8];

endmodule

// ### programmable_crc_engine.sv
// Programmable 16/32-bit CRC engine behind an AHB-Lite slave port.
// Assumes single word transfers, one slave per hready, and a standby
// level from the power controller that is asynchronous to hclk.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "crc_engine_cfg.svh"

// Overview of operation
// - Upper polynomial bytes take part only in 32-bit width
// - Lower polynomial bytes are used in both widths
// - Offset 6 holds polynomial bits 15:8, the next holds 7:0
// - Input field 01 mirrors each message byte; 00 passes it unchanged
// - Output field 01 mirrors bits inside each readout byte
// - Control bit 3 reads zero and ignores writes
// - Result invert returns the complement of the checksum on reads
// - Seed select on: data writes load seed; off: low data register writes carry message
// - Width select: zero gives 16-bit, one gives 32-bit generator
// - Clearing seed select starts calculation from the loaded seed
// - Each low data byte write folds all eight bits into the CRC, save one overwritten by a later write in standby
// - 16-bit seed and result sit in the two low data registers
// - 32-bit seed and result span all four data registers
// - Mirrored readout puts bit 24 at the top of the top byte
// - 0x1021 with seed 0xffff yields the CCITT CRC-16
// - Without seed select, writes to the upper data registers are dropped
// - Standby halts a pending calculation and resumes it afterwards
// - Reset: data 0xffffffff, polynomial 0x00001021, control zero
module programmable_crc_engine
  import crc_engine_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power state
  input wire logic deep_standby_state
);

  // Address phase
  logic take;
  logic addr_ok;
  reg_idx_t idx_a;

  // Data phase
  logic wr_ph_q;
  reg_idx_t wr_idx_q;
  logic wr_en;
  logic [7:0] wbyte;
  logic [4:0] lane;

  // Register state and forwarded next values
  logic [31:0] checksum_q;
  logic [31:0] checksum_d;
  logic [31:0] poly_q;
  logic [31:0] poly_d;
  ctrl_s ctrl_q;
  ctrl_s ctrl_d;

  // Message path
  logic seed_en;
  logic msg_en;
  logic step_en;
  logic [7:0] in_byte;
  logic pend_q;
  logic pend_d;
  logic [7:0] pend_byte_q;
  logic [7:0] pend_byte_d;

  // Standby synchroniser
  logic sb_meta_q;
  logic sb_q;

  // Readout
  logic [31:0] chk_inv;
  logic [31:0] chk_view;
  logic [7:0] rd_byte;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  crc_step_if step ();

  crc_byte_step u_step (
    .p(step.unit)
  );

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // Address decode; words above the control register are unmapped
  assign take = hsel && htrans[1] && hready;
  assign idx_a = haddr[5:2];
  assign addr_ok = (haddr[ADDR_W-1:6] == '0) &&
    (idx_a <= `CRC_IDX_CONTROL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      wr_idx_q <= '0;
    end else begin
      wr_ph_q <= take && hwrite && addr_ok &&
        (hsize == `CRC_HSIZE_WORD);
      wr_idx_q <= idx_a;
    end
  end

  assign wr_en = wr_ph_q;
  assign wbyte = hwdata[7:0];
  // Byte lane: index 0 and 4 map to the top byte, 3 and 7 to the bottom
  assign lane = {~wr_idx_q[1:0], 3'h0};

  // Standby is a level from another domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sb_meta_q <= 1'b0;
      sb_q <= 1'b0;
    end else begin
      sb_meta_q <= deep_standby_state;
      sb_q <= sb_meta_q;
    end
  end

  assign seed_en = wr_en && ctrl_q.seed_write_select &&
    (wr_idx_q <= `CRC_IDX_CHECKSUM_BYTE_0);
  // Only the low data register carries message bytes
  assign msg_en = wr_en && !ctrl_q.seed_write_select &&
    (wr_idx_q == `CRC_IDX_CHECKSUM_BYTE_0);
  assign in_byte = (ctrl_q.input_reverse_sel == REV_BITS) ?
    rev8(wbyte) : wbyte;

  assign step.crc_in = checksum_q;
  assign step.poly = poly_q;
  assign step.wide = ctrl_q.width_select;
  assign step.data = pend_q ? pend_byte_q : in_byte;

  // The last byte that arrives in standby is parked and folded in on wake-up; an earlier one is overwritten
  always_comb begin
    checksum_d = checksum_q;
    pend_d = pend_q;
    pend_byte_d = pend_byte_q;
    step_en = 1'b0;
    if (sb_q) begin
      if (msg_en) begin
        pend_d = 1'b1;
        pend_byte_d = in_byte;
      end
    end else if (msg_en || pend_q) begin
      step_en = 1'b1;
      checksum_d = step.crc_out;
      // A byte written on the wake-up cycle waits one clock behind
      pend_d = pend_q && msg_en;
      if (msg_en) begin
        pend_byte_d = in_byte;
      end
    end
    if (seed_en) begin
      checksum_d[lane +: 8] = wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      checksum_q <= `CRC_CHECKSUM_RST;
      pend_q <= 1'b0;
      pend_byte_q <= 8'h00;
    end else begin
      checksum_q <= checksum_d;
      pend_q <= pend_d;
      pend_byte_q <= pend_byte_d;
    end
  end

  always_comb begin
    poly_d = poly_q;
    if (wr_en && wr_idx_q[3:2] == 2'h1) begin
      poly_d[lane +: 8] = wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poly_q <= `CRC_POLY_RST;
    end else begin
      poly_q <= poly_d;
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_en && wr_idx_q == `CRC_IDX_CONTROL) begin
      ctrl_d = unpack_ctrl(wbyte);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= unpack_ctrl(`CRC_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Readout looks at next values so a read right behind a write is fresh
  assign chk_inv = ctrl_d.result_invert ? ~checksum_d : checksum_d;

  for (genvar b = 0; b < 4; b++) begin : g_out_byte
    assign chk_view[8*b +: 8] =
      (ctrl_d.output_reverse_sel == REV_BITS) ?
      rev8(chk_inv[8*b +: 8]) : chk_inv[8*b +: 8];
  end

  always_comb begin
    case (idx_a)
      `CRC_IDX_CHECKSUM_BYTE_3: rd_byte = chk_view[31:24];
      `CRC_IDX_CHECKSUM_BYTE_2: rd_byte = chk_view[23:16];
      `CRC_IDX_CHECKSUM_BYTE_1: rd_byte = chk_view[15:8];
      `CRC_IDX_CHECKSUM_BYTE_0: rd_byte = chk_view[7:0];
      `CRC_IDX_POLY_BYTE_3: rd_byte = poly_d[31:24];
      `CRC_IDX_POLY_BYTE_2: rd_byte = poly_d[23:16];
      `CRC_IDX_POLY_BYTE_1: rd_byte = poly_d[15:8];
      `CRC_IDX_POLY_BYTE_0: rd_byte = poly_d[7:0];
      `CRC_IDX_CONTROL: rd_byte = pack_ctrl(ctrl_d);
      default: rd_byte = 8'h00;
    endcase
  end

  // Zero wait states: read data is ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (take && !hwrite) begin
        hrdata_q <= addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking

  default disable iff (!hresetn);

  AST_CTRL_RSV_ZERO: assert property (
    take && !hwrite && addr_ok && idx_a == `CRC_IDX_CONTROL
    |=> hrdata[31:8] == 24'h000000 && !hrdata[`CRC_CTRL_RSV_BIT])
    else $error("control read shows reserved bits set");

  AST_SEED_LOAD: assert property (
    seed_en && wr_idx_q == `CRC_IDX_CHECKSUM_BYTE_0
    |=> checksum_q[7:0] == $past(hwdata[7:0]))
    else $error("seed byte not loaded into checksum");

  AST_UPPER_IGNORED: assert property (
    wr_en && !ctrl_q.seed_write_select && !pend_q &&
    wr_idx_q < `CRC_IDX_CHECKSUM_BYTE_0
    |=> $stable(checksum_q))
    else $error("upper data write changed checksum");

  AST_NARROW_UPPER: assert property (
    step_en && !ctrl_q.width_select && !seed_en
    |=> checksum_q[31:16] == $past(checksum_q[31:16]))
    else $error("16-bit step touched upper checksum half");

  AST_STANDBY_HOLD: assert property (
    sb_q && !seed_en |=> $stable(checksum_q))
    else $error("checksum moved during standby");

  AST_RESUME: assert property (
    pend_q && !sb_q && !msg_en |=> !pend_q ##1 !pend_q)
    else $error("parked byte not folded in after standby");

  AST_STEP_SAME_CYCLE: assert property (
    msg_en && !sb_q |-> step_en ##1 !pend_q || $past(pend_q))
    else $error("message byte not processed at once");

  AST_INVERT: assert property (
    take && !hwrite && idx_a == `CRC_IDX_CHECKSUM_BYTE_0 &&
    addr_ok &&
    ctrl_d.result_invert && ctrl_d.output_reverse_sel != REV_BITS
    |=> hrdata[7:0] == ~$past(checksum_d[7:0]))
    else $error("inverted readout mismatch");

  AST_OUT_REVERSE: assert property (
    take && !hwrite && idx_a == `CRC_IDX_CHECKSUM_BYTE_3 &&
    addr_ok &&
    !ctrl_d.result_invert && ctrl_d.output_reverse_sel == REV_BITS
    |=> hrdata[0] == $past(checksum_d[31]) &&
    hrdata[7] == $past(checksum_d[24]))
    else $error("mirrored readout misplaced bits");

  AST_BUS_OKAY: assert property (
    hreadyout && !hresp)
    else $error("slave stalled or answered with an error");

  AST_POLY_BYTE_1: assert property (
    wr_en && wr_idx_q == `CRC_IDX_POLY_BYTE_1
    |=> poly_q[15:8] == $past(hwdata[7:0]))
    else $error("polynomial bits 15:8 not written");

  AST_SEED_TOP: assert property (
    seed_en && wr_idx_q == `CRC_IDX_CHECKSUM_BYTE_3
    |=> checksum_q[31:24] == $past(hwdata[7:0]))
    else $error("top seed byte not loaded");

  AST_CTRL_WRITE: assert property (
    wr_en && wr_idx_q == `CRC_IDX_CONTROL
    |=> ctrl_q.width_select == $past(hwdata[`CRC_CTRL_WIDTH_BIT]))
    else $error("width select not taken from control write");

  // Checks the byte that really enters the step against the raw bus data
  AST_IN_REVERSE: assert property (
    msg_en && !sb_q && !pend_q && ctrl_q.input_reverse_sel == REV_BITS
    |-> step.data[7] == hwdata[0] && step.data[0] == hwdata[7])
    else $error("input byte not mirrored before the update");

  // First edge out of reset must still show every reset value
  AST_RESET_STATE: assert property (
    $rose(hresetn) |-> checksum_q == `CRC_CHECKSUM_RST &&
    poly_q == `CRC_POLY_RST && pack_ctrl(ctrl_q) == `CRC_CTRL_RST)
    else $error("state after reset differs from reset values");

  COV_SEED: cover property (seed_en ##[1:20] step_en);
  COV_STEP: cover property (step_en ##1 step_en);
  COV_PARK: cover property (sb_q && msg_en ##[1:50] !sb_q && pend_q);
  COV_INV_READ: cover property (take && !hwrite && ctrl_d.result_invert);
  COV_WIDE_STEP: cover property (step_en && ctrl_q.width_select);

endmodule

// ### programmable_crc_engine_test.sv
// Self-checking bench for the programmable CRC engine.
// Assumes the engine is the only slave, so hready follows hreadyout.
`timescale 1ns/1ps
`include "crc_engine_cfg.svh"

module programmable_crc_engine_test
  import crc_engine_pkg::*;
;
  localparam int CTL = `CRC_IDX_CONTROL;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic deep_standby_state;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int stalls = 0;
  logic [31:0] m_crc;
  logic [31:0] m_poly;
  logic [7:0] m_ctrl;
  logic [31:0] old;
  logic [31:0] x;
  logic [7:0] c;

  programmable_crc_engine #(.ADDR_W(12)) programmable_crc_engine_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .deep_standby_state(deep_standby_state)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [7:0] mirror(logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Reference fold, MSB first; 16-bit width leaves the upper half alone
  function automatic logic [31:0] fold(logic [31:0] s, logic [31:0] p,
    logic [7:0] d, logic wide);
    logic [31:0] v;
    v = s;
    if (wide) begin
      v = v ^ {d, 24'h000000};
      for (int i = 0; i < 8; i++) begin
        v = v[31] ? ((v << 1) ^ p) : (v << 1);
      end
    end else begin
      v[15:0] = v[15:0] ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
        v[15:0] = v[15] ? ((v[15:0] << 1) ^ p[15:0]) : (v[15:0] << 1);
      end
    end
    return v;
  endfunction

  function automatic logic [31:0] reg_exp(int idx);
    logic [31:0] v;
    logic [7:0] b;
    v = m_ctrl[2] ? ~m_crc : m_crc;
    b = v[8*(3-idx) +: 8];
    if (idx < 4)
      return {24'h000000, (m_ctrl[5:4] == REV_BITS) ? mirror(b) : b};
    if (idx < 8)
      return {24'h000000, m_poly[8*(7-idx) +: 8]};
    if (idx == 8)
      return {24'h000000, m_ctrl};
    return 32'h00000000;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic [3:0] idx, input logic wr_n,
    input logic [7:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {6'h00, idx, 2'h0};
    hwrite <= wr_n;
    hsize <= `CRC_HSIZE_WORD;
    stalls = 0;
    do begin
      @(posedge hclk);
      stalls++;
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do begin
      @(posedge hclk);
      stalls++;
    end while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    logic [31:0] r;
    bus(4'(idx), 1'b1, d, r);
    if (idx == CTL)
      m_ctrl = d & 8'hf7;
    else if (idx > 3)
      m_poly[8*(7-idx) +: 8] = d;
    else if (m_ctrl[1])
      m_crc[8*(3-idx) +: 8] = d;
    else if (idx == 3)
      m_crc = fold(m_crc, m_poly, (m_ctrl[7:6] == REV_BITS) ? mirror(d) : d,
        m_ctrl[0]);
  endtask

  task automatic rdchk(input int idx, input logic [31:0] e);
    logic [31:0] r;
    bus(4'(idx), 1'b0, 8'h00, r);
    check($sformatf("register %0d", idx), r, e);
    check("bus edges", stalls, 32'h00000002);
    check("response", {31'h00000000, hresp}, 32'h00000000);
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
    deep_standby_state = 1'b0;
    m_crc = 32'hffffffff;
    m_poly = 32'h00001021;
    m_ctrl = 8'h00;
    void'($urandom(32'h0e4c));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 12; i++) begin
      rdchk(i, reg_exp(i));
    end
    $display("test reset values done");
    wr(CTL, 8'hff);
    rdchk(CTL, 32'h000000f7);
    wr(CTL, 8'h02);
    wr(6, 8'h10);
    wr(7, 8'h21);
    wr(2, 8'hff);
    wr(3, 8'hff);
    wr(CTL, 8'h00);
    repeat (256) wr(3, 8'h41);
    rdchk(2, 32'h000000ea);
    rdchk(3, 32'h0000000b);
    $display("test ccitt done");
    // Alternating widths, random options; 16-bit runs carry junk upper polynomial
    for (int t = 0; t < 10; t++) begin
      c = 8'($urandom()) & 8'h55;
      c[0] = t[0];
      wr(CTL, c);
      for (int k = 4; k < 8; k++) begin
        wr(k, 8'($urandom()));
      end
      wr(CTL, c | 8'h02);
      for (int k = 0; k < 4; k++) begin
        wr(k, 8'($urandom()));
      end
      wr(CTL, c);
      repeat ($urandom_range(12, 1)) wr(3, 8'($urandom()));
      for (int k = (c[0] ? 0 : 2); k < 9; k++) begin
        rdchk(k, reg_exp(k));
      end
      wr(CTL, c ^ 8'h04);
      rdchk(3, reg_exp(3));
    end
    $display("test random runs done");
    wr(CTL, 8'h01);
    wr(0, 8'h5a);
    wr(1, 8'ha5);
    wr(2, 8'h3c);
    for (int k = 0; k < 4; k++) begin
      rdchk(k, reg_exp(k));
    end
    wr(CTL, 8'h11);
    rdchk(0, reg_exp(0));
    wr(CTL, 8'h05);
    rdchk(3, reg_exp(3));
    $display("test upper data writes done");
    deep_standby_state <= 1'b1;
    repeat (4) @(posedge hclk);
    old = reg_exp(3);
    wr(3, 8'hc3);
    bus(4'h3, 1'b0, 8'h00, x);
    check("standby hold", x, old);
    deep_standby_state <= 1'b0;
    repeat (4) @(posedge hclk);
    for (int k = 0; k < 4; k++) begin
      rdchk(k, reg_exp(k));
    end
    $display("test standby done");
    results();
  end
endmodule
